// [shared/event_router_pkg.sv]
// Package: register map, field positions and timing for the SMI/SCI event router
//
// Notes on behaviour
// - Each event source has its own status bit; override, watchdog and intrusion ignore their enable bits.
// - SCI routed events need sci_select 1, except release; SMI needs it 0.
// - No SMI at all unless smi_master_enable is 1.
// - Enabled SMI event while end_of_smi set clears it and sends one SMI message.
// - No further SMI until software writes 1 to end_of_smi; then resend if pending.
// - SCI is a level, held while any enabled SCI status remains set.
// - SCI routes to lines 9 to 11, or 20 to 23 only in advanced mode; code checks mode only on route writes and keeps 20 to 23 after it clears.
// - Button override forces soft-off at once and sets status; SCI only, no enable.
// - Override SCI only after wake, if status not cleared before sci_select set.
// - Writing firmware_release_bit sets global status, which raises SCI regardless of select.
// - PME message sets pcie_pme_status; with enable raises SCI via gp_event1; never SMI.
// - Hot-plug messages set gp_event1 status; SCI or SMI via hot-plug enable, never wake.
// - PM timer overflow every 2.34 s sets status; raises SCI or SMI when enabled.
// - Any write to port B2h sets apm status; SMI when apm_command_enable is 1.
// - Chassis intrusion sets detect status; SMI when intrusion_select equals binary 10.
// - Write enable rising with lock, or flash write while enabled, sets status; SMI when flash enable is 1.
// - Watchdog data-in write, watchdog timeout or processor message raise SMI, no enable.
// - Pin lockdown bit falling sets unlock status; SMI when unlock enable is 1.
// - Writing sleep_go with sleep enable and SMI master set sets sleep status and SMI instead of sleeping.
// - SMBus host notify sets smbus and notify status; SMI when notify enable set.
// - Idle-state flows exchange messages and drive pm_sync_sideband; no voltage or clock.
package event_router_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_COMMAND = 8'h0C;
  localparam logic [7:0] OFF_ROUTE = 8'h10;

  // ---------------------------------------------------------------
  // Event bit positions, shared by enable and status registers
  // ---------------------------------------------------------------
  localparam int EV_PME = 0;
  localparam int EV_HOTPLUG = 1;
  localparam int EV_TIMER = 2;
  localparam int EV_APM = 3;
  localparam int EV_INTRUSION = 4;
  localparam int EV_FLASH = 5;
  localparam int EV_WATCHDOG = 6;
  localparam int EV_UNLOCK = 7;
  localparam int EV_SLEEP = 8;
  localparam int EV_SMBUS = 9;
  localparam int EV_NOTIFY = 10;
  localparam int EV_OVERRIDE = 11;
  localparam int EV_RELEASE = 12;
  localparam int EV_OS_RELEASE = 13;
  localparam int EV_GPE1 = 14;
  localparam int NUM_EVENTS = 15;

  // Events able to reach SCI / SMI
  localparam logic [14:0] SCI_CAPABLE = 15'h4807;
  localparam logic [14:0] SMI_CAPABLE = 15'h27FE;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTL_SCI_SELECT = 0;
  localparam int CTL_SMI_MASTER = 1;
  localparam int CTL_END_OF_SMI = 2;
  localparam int CTL_FLASH_WE = 3;
  localparam int CTL_FLASH_LOCK = 4;
  localparam int CTL_PIN_LOCK = 5;
  localparam int CTL_APIC_MODE = 6;
  localparam int CTL_INTR_SEL_LO = 7;
  localparam logic [1:0] INTRUSION_TO_SMI = 2'h2;

  // Command register write-one strobes
  localparam int CMD_FW_RELEASE = 0;
  localparam int CMD_OS_RELEASE = 1;
  localparam int CMD_SLEEP_GO = 2;
  localparam int CMD_WATCHDOG_DATA = 3;
  localparam int CMD_APM_PORT = 4;

  // SCI route line numbers
  localparam logic [4:0] ROUTE_RESET = 5'h09;
  localparam logic [4:0] ROUTE_LOW_MIN = 5'h09;
  localparam logic [4:0] ROUTE_LOW_MAX = 5'h0B;
  localparam logic [4:0] ROUTE_HIGH_MIN = 5'h14;
  localparam logic [4:0] ROUTE_HIGH_MAX = 5'h17;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real TIMER_PERIOD_S = 2.34;
  localparam longint TIMER_CYCLES = longint'(TIMER_PERIOD_S * 1.0e9 / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic write;
    logic read;
  } reg_req_type;

  typedef struct packed {
    logic pme_message;
    logic hotplug_message;
    logic flash_write_attempt;
    logic watchdog_timeout;
    logic watchdog_smi_message;
    logic smbus_notify;
    logic button_override;
    logic wake_to_working;
    logic idle_message;
  } event_in_type;

endpackage : event_router_pkg

// [design/smi_sci_event_router.sv]
// Module: SMI/SCI power-management event router
`timescale 1ns/1ps
module smi_sci_event_router #(
  parameter longint TIMER_LIMIT = event_router_pkg::TIMER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire event_router_pkg::reg_req_type reg_req,
  output logic [31:0] reg_rdata,
  input wire event_router_pkg::event_in_type events_raw,
  input wire logic chassis_intrusion_n,
  output logic sci_level,
  output logic [4:0] sci_line,
  output logic virtual_wire_message,
  output logic soft_off_request,
  output logic sleep_go,
  output logic pm_sync_sideband,
  output logic idle_message_ack
);
  import event_router_pkg::*;

  typedef struct packed {
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] enable;
    logic [8:0] control;
    logic [4:0] route;
    logic [31:0] timer;
    event_in_type sync1;
    event_in_type sync2;
    event_in_type last;
    logic intr1;
    logic intr2;
    logic intr_last;
    logic smi_msg;
    logic override_armed;
    logic soft_off;
    logic sleep_pulse;
    logic sync_pin;
    logic idle_ack;
    logic sci;
    logic [31:0] rdata;
  } state_type;

  state_type state;
  state_type next_state;

  function automatic logic route_legal(input logic [4:0] line, input logic apic);
    route_legal = (line >= ROUTE_LOW_MIN && line <= ROUTE_LOW_MAX) ||
                  (apic && line >= ROUTE_HIGH_MIN && line <= ROUTE_HIGH_MAX);
  endfunction : route_legal

  function automatic logic hit(input logic [7:0] off);
    hit = reg_req.addr == off;
  endfunction : hit

  logic [NUM_EVENTS-1:0] set_ev;
  logic [NUM_EVENTS-1:0] pending;
  logic [31:0] wd;
  logic wr;
  logic smi_any;
  logic sci_any;
  logic rise_event;
  event_in_type edge_in;

  always_comb begin
    next_state = state;
    set_ev = '0;
    wd = reg_req.wdata;
    wr = reg_req.write;
    // Synchronise pins, then edge-detect on second stage
    next_state.sync1 = events_raw;
    next_state.sync2 = state.sync1;
    next_state.last = state.sync2;
    edge_in = state.sync2 & ~state.last;
    next_state.intr1 = ~chassis_intrusion_n;
    next_state.intr2 = state.intr1;
    next_state.intr_last = state.intr2;
    next_state.sleep_pulse = 1'b0;
    next_state.idle_ack = 1'b0;
    next_state.smi_msg = 1'b0;

    // -------------------------------------------------------------
    // Event capture
    // -------------------------------------------------------------
    if (edge_in.pme_message) begin
      set_ev[EV_PME] = 1'b1;
    end
    if (edge_in.hotplug_message) begin
      set_ev[EV_HOTPLUG] = 1'b1;
    end
    next_state.timer = state.timer + 32'h1;
    if (64'(state.timer) >= 64'(TIMER_LIMIT - 1)) begin
      next_state.timer = '0;
      set_ev[EV_TIMER] = 1'b1;
    end
    if (state.intr2 && !state.intr_last) begin
      set_ev[EV_INTRUSION] = 1'b1;
    end
    if (edge_in.flash_write_attempt && state.control[CTL_FLASH_WE]) begin
      set_ev[EV_FLASH] = 1'b1;
    end
    if (edge_in.watchdog_timeout || edge_in.watchdog_smi_message) begin
      set_ev[EV_WATCHDOG] = 1'b1;
    end
    if (edge_in.smbus_notify) begin
      set_ev[EV_SMBUS] = 1'b1;
      set_ev[EV_NOTIFY] = 1'b1;
    end
    if (edge_in.button_override) begin
      set_ev[EV_OVERRIDE] = 1'b1;
      next_state.soft_off = 1'b1;
      next_state.override_armed = 1'b0;
    end
    // Override SCI armed only once the system is back in working state
    if (edge_in.wake_to_working) begin
      next_state.soft_off = 1'b0;
      next_state.override_armed = 1'b1;
    end
    // Idle-state message answered and mirrored on the sideband pin
    if (edge_in.idle_message) begin
      next_state.idle_ack = 1'b1;
    end
    next_state.sync_pin = state.sync2.idle_message;

    // -------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------
    if (wr && hit(OFF_CONTROL)) begin
      next_state.control[CTL_SCI_SELECT] = wd[CTL_SCI_SELECT];
      next_state.control[CTL_SMI_MASTER] = wd[CTL_SMI_MASTER];
      next_state.control[CTL_APIC_MODE] = wd[CTL_APIC_MODE];
      next_state.control[CTL_INTR_SEL_LO +: 2] = wd[CTL_INTR_SEL_LO +: 2];
      next_state.control[CTL_FLASH_WE] = wd[CTL_FLASH_WE];
      next_state.control[CTL_PIN_LOCK] = wd[CTL_PIN_LOCK];
      // Lock bit is write-once until reset
      if (wd[CTL_FLASH_LOCK]) begin
        next_state.control[CTL_FLASH_LOCK] = 1'b1;
      end
      // Writing 1 re-arms SMI delivery; writing 0 has no effect
      if (wd[CTL_END_OF_SMI]) begin
        next_state.control[CTL_END_OF_SMI] = 1'b1;
      end
      if (wd[CTL_FLASH_WE] && !state.control[CTL_FLASH_WE] &&
          state.control[CTL_FLASH_LOCK]) begin
        set_ev[EV_FLASH] = 1'b1;
      end
      if (!wd[CTL_PIN_LOCK] && state.control[CTL_PIN_LOCK]) begin
        set_ev[EV_UNLOCK] = 1'b1;
      end
      // Override disarmed if its status is already clear when SCI gets selected
      if (wd[CTL_SCI_SELECT] && !state.control[CTL_SCI_SELECT] &&
          !state.status[EV_OVERRIDE]) begin
        next_state.override_armed = 1'b0;
      end
    end
    if (wr && hit(OFF_ENABLE)) begin
      next_state.enable = wd[NUM_EVENTS-1:0];
    end
    if (wr && hit(OFF_ROUTE) && route_legal(wd[4:0], state.control[CTL_APIC_MODE])) begin
      next_state.route = wd[4:0];
    end
    if (wr && hit(OFF_COMMAND)) begin
      if (wd[CMD_FW_RELEASE]) begin
        set_ev[EV_RELEASE] = 1'b1;
      end
      if (wd[CMD_OS_RELEASE]) begin
        set_ev[EV_OS_RELEASE] = 1'b1;
      end
      if (wd[CMD_WATCHDOG_DATA]) begin
        set_ev[EV_WATCHDOG] = 1'b1;
      end
      if (wd[CMD_APM_PORT]) begin
        set_ev[EV_APM] = 1'b1;
      end
      if (wd[CMD_SLEEP_GO]) begin
        // Trapped into SMI instead of sleeping when enabled
        if (state.enable[EV_SLEEP] && state.control[CTL_SMI_MASTER]) begin
          set_ev[EV_SLEEP] = 1'b1;
        end else begin
          next_state.sleep_pulse = 1'b1;
        end
      end
    end
    // PME and hot-plug also reported through the general-purpose group
    if (set_ev[EV_PME] || set_ev[EV_HOTPLUG]) begin
      set_ev[EV_GPE1] = 1'b1;
    end

    // Write-one-to-clear, with a new event winning over the clear
    next_state.status = state.status;
    if (wr && hit(OFF_STATUS)) begin
      next_state.status = state.status & ~wd[NUM_EVENTS-1:0];
    end
    next_state.status = next_state.status | set_ev;

    // -------------------------------------------------------------
    // Delivery
    // -------------------------------------------------------------
    pending = state.status & state.enable;
    pending[EV_OVERRIDE] = state.status[EV_OVERRIDE] & state.override_armed;
    pending[EV_WATCHDOG] = state.status[EV_WATCHDOG];
    pending[EV_SMBUS] = 1'b0;
    pending[EV_GPE1] = state.status[EV_GPE1] & state.enable[EV_PME] & state.status[EV_PME];
    pending[EV_INTRUSION] = state.status[EV_INTRUSION] &
                            (state.control[CTL_INTR_SEL_LO +: 2] == INTRUSION_TO_SMI);
    sci_any = state.control[CTL_SCI_SELECT] && |(pending & SCI_CAPABLE);
    rise_event = state.status[EV_RELEASE];
    smi_any = !state.control[CTL_SCI_SELECT] && state.control[CTL_SMI_MASTER] &&
              |(pending & SMI_CAPABLE);
    if (smi_any && state.control[CTL_END_OF_SMI]) begin
      next_state.control[CTL_END_OF_SMI] = 1'b0;
      next_state.smi_msg = 1'b1;
    end

    // -------------------------------------------------------------
    // Register read, data one cycle later
    // -------------------------------------------------------------
    next_state.rdata = '0;
    if (reg_req.read) begin
      case (reg_req.addr)
        OFF_CONTROL: next_state.rdata = {23'h0, state.control};
        OFF_ENABLE: next_state.rdata = {17'h0, state.enable};
        OFF_STATUS: next_state.rdata = {17'h0, state.status};
        OFF_ROUTE: next_state.rdata = {27'h0, state.route};
        default: next_state.rdata = '0;
      endcase
    end
    next_state.sci = sci_any || rise_event;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
      state.control[CTL_END_OF_SMI] <= 1'b1;
      state.route <= ROUTE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign sci_level = state.sci;
  assign sci_line = state.route;
  assign virtual_wire_message = state.smi_msg;
  assign soft_off_request = state.soft_off;
  assign sleep_go = state.sleep_pulse;
  assign pm_sync_sideband = state.sync_pin;
  assign idle_message_ack = state.idle_ack;

endmodule : smi_sci_event_router

// [sim/event_router_checker_assertions.sv]
// Checker: port-level assertions for the SMI/SCI event router
`timescale 1ns/1ps
module event_router_checker #(
  parameter longint TIMER_LIMIT = event_router_pkg::TIMER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire event_router_pkg::reg_req_type reg_req,
  input wire logic [31:0] reg_rdata,
  input wire event_router_pkg::event_in_type events_raw,
  input wire logic sci_level,
  input wire logic [4:0] sci_line,
  input wire logic virtual_wire_message,
  input wire logic soft_off_request,
  input wire logic sleep_go,
  input wire logic pm_sync_sideband
);
  import event_router_pkg::*;
  // ------
  // Shadow of control state
  // ------
  logic master_sh;
  logic select_sh;
  logic armed;
  logic [7:0] ovr_age;
  wire ctl_wr = reg_req.write && reg_req.addr == OFF_CONTROL;
  wire route_wr = reg_req.write && reg_req.addr == OFF_ROUTE;
  wire sleep_wr = reg_req.write && reg_req.addr == OFF_COMMAND && reg_req.wdata[CMD_SLEEP_GO];
  wire smi_ok = master_sh && !select_sh;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      master_sh <= 1'b0;
      select_sh <= 1'b0;
      armed <= 1'b1;
      ovr_age <= 8'hFF;
    end else begin
      if (ctl_wr) begin
        master_sh <= reg_req.wdata[CTL_SMI_MASTER];
        select_sh <= reg_req.wdata[CTL_SCI_SELECT];
      end
      if (ctl_wr && reg_req.wdata[CTL_END_OF_SMI])
        armed <= 1'b1;
      else if (virtual_wire_message)
        armed <= 1'b0;
      if (events_raw.button_override)
        ovr_age <= 8'h00;
      else if (ovr_age != 8'hFF)
        ovr_age <= ovr_age + 8'h01;
    end
  end
  // ------
  // Assertions
  // ------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(reg_req.read) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer");
  route_legal_a: assert property (sci_line inside {[5'h09:5'h0B], [5'h14:5'h17]}
    && ($stable(sci_line) || $past(route_wr) || $past(route_wr, 2)))
    else $error("sci line illegal or changed unasked");
  smi_gate_a: assert property (virtual_wire_message |-> $past(smi_ok) || $past(smi_ok, 2))
    else $error("smi sent while gated off");
  smi_rearm_a: assert property (virtual_wire_message |-> armed)
    else $error("smi sent before end of smi write");
  sci_hold_a: assert property ($fell(sci_level) |->
    $past(reg_req.write) || $past(reg_req.write, 2) || $past(reg_req.write, 3))
    else $error("sci dropped without software write");
  override_off_a: assert property ($rose(soft_off_request) |-> ovr_age < 8'h0C)
    else $error("soft off without override");
  sleep_cause_a: assert property (sleep_go |-> $past(sleep_wr) || $past(sleep_wr, 2))
    else $error("sleep proceeded without command");
  sleep_pulse_a: assert property (sleep_go |=> !sleep_go)
    else $error("sleep pulse too long");
  sideband_follow_a: assert property (events_raw.idle_message [*8] |=> pm_sync_sideband)
    else $error("sideband not following idle message");
  sideband_drop_a: assert property (!events_raw.idle_message [*8] |=> !pm_sync_sideband)
    else $error("sideband stuck high");
  smi_seen_c: cover property (virtual_wire_message);
  sci_seen_c: cover property ($rose(sci_level));
  off_seen_c: cover property ($rose(soft_off_request));
endmodule : event_router_checker
bind smi_sci_event_router event_router_checker #(.TIMER_LIMIT(TIMER_LIMIT)) checker_u (
  .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .events_raw(events_raw), .sci_level(sci_level), .sci_line(sci_line),
  .virtual_wire_message(virtual_wire_message), .soft_off_request(soft_off_request),
  .sleep_go(sleep_go), .pm_sync_sideband(pm_sync_sideband)
);

// [sim/host_model.sv]
// Partner model: processor side counting SMI messages
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic virtual_wire_message,
  output int smi_count
);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      smi_count <= 0;
    else if (virtual_wire_message === 1'b1)
      smi_count <= smi_count + 1;
  end
endmodule : host_model

// [sim/tb.sv]
// Testbench: register-level scenarios for the SMI/SCI event router
`timescale 1ns/1ps
module tb;
  import event_router_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  reg_req_type req = '0;
  event_in_type ev = '0;
  logic intr_n = 1'b1;
  logic [31:0] rdata;
  logic [4:0] sci_line;
  logic sci_level, vwm, soft_off, sleep_go, pm_sync, ack;
  int smi_count, failures = 0, checked = 0, sleeps = 0, n = 0, acks = 0;
  logic [31:0] en_tab [4] = '{32'h8, 32'h0, 32'h100, 32'h4};
  logic [31:0] cmd_tab [4] = '{32'h10, 32'h8, 32'h4, 32'h0};
  int st_tab [4] = '{3, 6, 8, 2};
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sleep_go === 1'b1) sleeps <= sleeps + 1;
  always @(posedge sys_clk) if (ack === 1'b1) acks <= acks + 1;
  smi_sci_event_router #(.TIMER_LIMIT(100)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .reg_req(req), .reg_rdata(rdata), .events_raw(ev),
    .chassis_intrusion_n(intr_n), .sci_level(sci_level), .sci_line(sci_line),
    .virtual_wire_message(vwm), .soft_off_request(soft_off), .sleep_go(sleep_go),
    .pm_sync_sideband(pm_sync), .idle_message_ack(ack)
  );
  host_model host_u (.sys_clk(sys_clk), .rst(rst), .virtual_wire_message(vwm),
    .smi_count(smi_count));
  // ------
  // Tasks
  // ------
  task automatic final_report;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge sys_clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    req <= '0;
    #1;
    chk(rdata & m, exp);
  endtask : rd
  task automatic wait_smi(input int cnt);
    for (int i = 0; i < 300 && smi_count != cnt; i++) @(posedge sys_clk);
    chk(smi_count, cnt);
    if (smi_count != cnt) final_report();
  endtask : wait_smi
  task automatic quiet(input int cnt);
    repeat (30) @(posedge sys_clk);
    chk(smi_count, cnt);
  endtask : quiet
  task automatic pulse(input event_in_type e);
    @(posedge sys_clk);
    ev <= e;
    repeat (4) @(posedge sys_clk);
    ev <= '0;
    repeat (10) @(posedge sys_clk);
  endtask : pulse
  task automatic smi_case(input logic [31:0] ctl, input event_in_type e, input logic [31:0] m);
    wr(OFF_CONTROL, ctl);
    pulse(e);
    n++;
    wait_smi(n);
    rd(OFF_STATUS, m, m);
    wr(OFF_STATUS, 32'h7FFF);
  endtask : smi_case
  // ------
  // Main sequence
  // ------
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFF_CONTROL, 32'h7, 32'h4);
    wr(OFF_ROUTE, 32'h14);
    rd(OFF_ROUTE, 32'h1F, 32'h9);
    wr(OFF_ROUTE, 32'hB);
    rd(OFF_ROUTE, 32'h1F, 32'hB);
    wr(OFF_CONTROL, 32'h44);
    wr(OFF_ROUTE, 32'h17);
    rd(OFF_ROUTE, 32'h1F, 32'h17);
    chk(sci_line, 5'h17);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_ENABLE, en_tab[k]);
      wr(OFF_CONTROL, 32'h6);
      if (cmd_tab[k] != 0) wr(OFF_COMMAND, cmd_tab[k]);
      n++;
      wait_smi(n);
      rd(OFF_STATUS, 32'h1 << st_tab[k], 32'h1 << st_tab[k]);
      wr(OFF_ENABLE, 32'h0);
      wr(OFF_STATUS, 32'h7FFF);
    end
    chk(sleeps, 0);
    wr(OFF_COMMAND, 32'h4);
    quiet(n);
    chk(sleeps, 1);
    wr(OFF_ENABLE, 32'h8);
    wr(OFF_CONTROL, 32'h6);
    wr(OFF_COMMAND, 32'h10);
    n++;
    wait_smi(n);
    wr(OFF_COMMAND, 32'h10);
    quiet(n);
    wr(OFF_CONTROL, 32'h6);
    n++;
    wait_smi(n);
    wr(OFF_CONTROL, 32'h4);
    wr(OFF_COMMAND, 32'h10);
    quiet(n);
    wr(OFF_CONTROL, 32'h7);
    quiet(n);
    wr(OFF_ENABLE, 32'h1);
    pulse(event_in_type'{pme_message: 1'b1, default: 1'b0});
    chk(sci_level, 1'b1);
    rd(OFF_STATUS, 32'h1, 32'h1);
    chk(sci_level, 1'b1);
    wr(OFF_ENABLE, 32'h0);
    wr(OFF_STATUS, 32'h7FFF);
    wr(OFF_CONTROL, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk(sci_level, 1'b0);
    wr(OFF_COMMAND, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk(sci_level, 1'b1);
    rd(OFF_STATUS, 32'h1000, 32'h1000);
    wr(OFF_STATUS, 32'h7FFF);
    pulse(event_in_type'{button_override: 1'b1, default: 1'b0});
    chk(soft_off, 1'b1);
    rd(OFF_STATUS, 32'h800, 32'h800);
    chk(sci_level, 1'b0);
    pulse(event_in_type'{wake_to_working: 1'b1, default: 1'b0});
    chk(soft_off, 1'b0);
    wr(OFF_CONTROL, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk(sci_level, 1'b1);
    wr(OFF_STATUS, 32'h7FFF);
    wr(OFF_CONTROL, 32'h106);
    @(posedge sys_clk);
    intr_n <= 1'b0;
    n++;
    wait_smi(n);
    intr_n <= 1'b1;
    rd(OFF_STATUS, 32'h10, 32'h10);
    @(posedge sys_clk);
    ev <= event_in_type'{idle_message: 1'b1, default: 1'b0};
    repeat (10) @(posedge sys_clk);
    chk(pm_sync, 1'b1);
    ev <= '0;
    repeat (10) @(posedge sys_clk);
    chk(pm_sync, 1'b0);
    chk(acks, 1);
    wr(OFF_STATUS, 32'h7FFF);
    wr(OFF_ENABLE, 32'h4A2);
    smi_case(32'h6, event_in_type'{hotplug_message: 1'b1, default: 1'b0}, 32'h4002);
    wr(OFF_CONTROL, 32'h16);
    smi_case(32'h1E, '0, 32'h20);
    smi_case(32'h1E, event_in_type'{flash_write_attempt: 1'b1, default: 1'b0},
      32'h20);
    wr(OFF_CONTROL, 32'h26);
    smi_case(32'h6, '0, 32'h80);
    smi_case(32'h6, event_in_type'{smbus_notify: 1'b1, default: 1'b0}, 32'h600);
    final_report();
  end
endmodule : tb
